// ### verilog/pgd_generator.v
// PWM generator unit: counter, comparators, action logic, dead-band, event select
// How it works
// - One 16-bit counter, two comparators, action generator, dead-band, event selector.
// - Period is set by a 16-bit load value.
// - Both outputs come from the same counter, so same frequency.
// - Down mode counts load to zero, then reloads.
// - Up/down mode counts zero to load and back, repeatedly.
// - Direction low in down mode, toggles at turns in up/down mode.
// - One-cycle pulses when counter is zero and when it equals load.
// - In down mode load pulse follows the zero pulse directly.
// - Each comparator pulses one cycle when counter equals its value.
// - Matches split by direction into up-match and down-match events.
// - A compare value above load never matches.
// - Down mode uses zero, load, A down and B down events.
// - Up/down mode uses zero, load and both up and down matches.
// - Matches coinciding with zero or load are dropped.
// - First output uses only A matches, second only B matches.
// - Each event per output: keep, toggle, drive low, drive high.
// - Dead-band disabled passes both outputs through.
// - Enabled: first output is input with rising edge delayed.
// - Enabled: second is inverted input, rising lags falling edge by delay.
// - Immediate mode: new load or compare takes effect at next zero.
// - Sync mode waits for global strobe then next zero; per value choice.
// - Interrupt fires on any selected raw event, ignoring dead-band.
`timescale 1ns/100ps
`include "pgd_consts.vh"
module pgd_generator #(
	parameter CNT_W = `PGD_CNT_W,
	parameter DB_W = `PGD_DB_W
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Control
	input wire run,
	input wire updown_mode,
	input wire load_sync_mode,
	input wire cmpa_sync_mode,
	input wire cmpb_sync_mode,
	input wire global_update,
	input wire db_enable,
	// Values
	input wire [CNT_W-1:0] load_value,
	input wire load_write,
	input wire [CNT_W-1:0] cmpa_value,
	input wire cmpa_write,
	input wire [CNT_W-1:0] cmpb_value,
	input wire cmpb_write,
	input wire [DB_W-1:0] db_rise,
	input wire [DB_W-1:0] db_fall,
	// Actions, two bits per event in event order
	input wire [`PGD_ACTS_W-1:0] acts_first,
	input wire [`PGD_ACTS_W-1:0] acts_second,
	// Interrupt event selection
	input wire [`PGD_NEV-1:0] irq_select,
	// Outputs
	output wire pwm_out_a,
	output wire pwm_out_b,
	output reg irq,
	output reg direction,
	output reg [CNT_W-1:0] count,
	output reg [`PGD_NEV-1:0] events
);
	reg [CNT_W-1:0] load_act, cmpa_act, cmpb_act;
	reg [CNT_W-1:0] load_pend, cmpa_pend, cmpb_pend;
	reg load_pv, cmpa_pv, cmpb_pv;
	reg load_arm, cmpa_arm, cmpb_arm;
	reg first_gen_output, second_gen_output;
	reg [CNT_W-1:0] next_count;
	reg next_direction;
	wire at_zero, at_load, ma, mb, use_ev_up;
	wire [`PGD_NEV-1:0] ev;
	wire load_take;
	wire cmpa_take;
	wire cmpb_take;
	wire [`PGD_ACTS_W-1:0] pick_first;
	wire [`PGD_ACTS_W-1:0] pick_second;
	genvar gi;

	// Apply one two-bit action to a level
	function apply_act;
		input cur;
		input [`PGD_ACT_W-1:0] act;
		begin
			case (act)
				`PGD_ACT_TOGGLE: apply_act = ~cur;
				`PGD_ACT_LOW: apply_act = 1'b0;
				`PGD_ACT_HIGH: apply_act = 1'b1;
				default: apply_act = cur;
			endcase
		end
	endfunction

	// Pending value is usable: immediate, or sync mode already armed by strobe
	function ready_at_zero;
		input pv;
		input sync_mode;
		input arm;
		begin
			ready_at_zero = pv && (!sync_mode || arm);
		end
	endfunction

	// Match only while the compare value is inside the period
	function cmp_hit;
		input [CNT_W-1:0] cnt;
		input [CNT_W-1:0] cmp;
		input [CNT_W-1:0] top;
		begin
			cmp_hit = (cnt == cmp) && (cmp <= top);
		end
	endfunction

	// Raw event decode on the current count
	assign at_zero = (count == `PGD_ZERO16);
	assign at_load = (count == load_act);
	assign ma = cmp_hit(count, cmpa_act, load_act);
	assign mb = cmp_hit(count, cmpb_act, load_act);
	assign use_ev_up = updown_mode && direction;
	assign ev[`PGD_EV_ZERO] = at_zero;
	assign ev[`PGD_EV_LOAD] = at_load;
	assign ev[`PGD_EV_AUP] = ma && use_ev_up && !at_zero && !at_load;
	assign ev[`PGD_EV_ADN] = ma && !use_ev_up && !at_zero && !at_load;
	assign ev[`PGD_EV_BUP] = mb && use_ev_up && !at_zero && !at_load;
	assign ev[`PGD_EV_BDN] = mb && !use_ev_up && !at_zero && !at_load;

	// Per-event action picks: keep unless that event fired this cycle
	generate
		for (gi = 0; gi < `PGD_NEV; gi = gi + 1) begin : g_pick
			assign pick_first[2*gi+1:2*gi] = ev[gi] ? acts_first[2*gi+1:2*gi] : `PGD_ACT_KEEP;
			assign pick_second[2*gi+1:2*gi] = ev[gi] ? acts_second[2*gi+1:2*gi] : `PGD_ACT_KEEP;
		end
	endgenerate

	// Counter next state
	always @* begin
		next_count = count;
		next_direction = direction;
		if (!updown_mode) begin
			next_direction = 1'b0;
			if (at_zero)
				next_count = load_act;
			else
				next_count = count - `PGD_ONE16;
		end else begin
			if (direction) begin
				if (count >= load_act) begin
					next_direction = 1'b0;
					next_count = count - `PGD_ONE16;
				end else
					next_count = count + `PGD_ONE16;
			end else begin
				if (at_zero) begin
					next_direction = 1'b1;
					next_count = count + `PGD_ONE16;
				end else
					next_count = count - `PGD_ONE16;
			end
			// Degenerate zero period holds at zero
			if (load_act == `PGD_ZERO16)
				next_count = `PGD_ZERO16;
		end
	end

	// Pending values go live only at a counter zero while running
	assign load_take = run && at_zero && ready_at_zero(load_pv, load_sync_mode, load_arm);
	assign cmpa_take = run && at_zero && ready_at_zero(cmpa_pv, cmpa_sync_mode, cmpa_arm);
	assign cmpb_take = run && at_zero && ready_at_zero(cmpb_pv, cmpb_sync_mode, cmpb_arm);

	// Counter and direction; both outputs share this one counter
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= `PGD_ZERO16;
			direction <= 1'b0;
		end else if (run) begin
			count <= next_count;
			direction <= next_direction;
			// A down-mode reload takes the new period at once
			if (load_take && !updown_mode) begin
				count <= load_pend;
			end
		end
	end

	// Event pulses and interrupt trail the count they describe by one cycle
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			events <= {`PGD_NEV{1'b0}};
			irq <= 1'b0;
		end else begin
			events <= run ? ev : {`PGD_NEV{1'b0}};
			irq <= run && |(ev & irq_select);
		end
	end

	// Load shadow; a fresh write wins over consumption in the same cycle
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			load_act <= `PGD_ZERO16;
			load_pend <= `PGD_ZERO16;
			load_pv <= 1'b0;
			load_arm <= 1'b0;
		end else begin
			if (global_update) begin
				load_arm <= load_pv;
			end
			if (load_take) begin
				load_act <= load_pend;
				load_pv <= 1'b0;
				load_arm <= 1'b0;
			end
			if (load_write) begin
				load_pend <= load_value;
				load_pv <= 1'b1;
				load_arm <= 1'b0;
			end
		end
	end

	// Compare A shadow, same update rules as the load
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmpa_act <= `PGD_ZERO16;
			cmpa_pend <= `PGD_ZERO16;
			cmpa_pv <= 1'b0;
			cmpa_arm <= 1'b0;
		end else begin
			if (global_update) begin
				cmpa_arm <= cmpa_pv;
			end
			if (cmpa_take) begin
				cmpa_act <= cmpa_pend;
				cmpa_pv <= 1'b0;
				cmpa_arm <= 1'b0;
			end
			if (cmpa_write) begin
				cmpa_pend <= cmpa_value;
				cmpa_pv <= 1'b1;
				cmpa_arm <= 1'b0;
			end
		end
	end

	// Compare B shadow, same update rules as the load
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmpb_act <= `PGD_ZERO16;
			cmpb_pend <= `PGD_ZERO16;
			cmpb_pv <= 1'b0;
			cmpb_arm <= 1'b0;
		end else begin
			if (global_update) begin
				cmpb_arm <= cmpb_pv;
			end
			if (cmpb_take) begin
				cmpb_act <= cmpb_pend;
				cmpb_pv <= 1'b0;
				cmpb_arm <= 1'b0;
			end
			if (cmpb_write) begin
				cmpb_pend <= cmpb_value;
				cmpb_pv <= 1'b1;
				cmpb_arm <= 1'b0;
			end
		end
	end

	// First output: zero, load, then its own A match; B events never reach it
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			first_gen_output <= 1'b0;
		end else if (run) begin
			first_gen_output <= apply_act(apply_act(apply_act(apply_act(first_gen_output,
				pick_first[1:0]), pick_first[3:2]),
				pick_first[5:4]), pick_first[7:6]);
		end
	end

	// Second output: zero, load, then its own B match; A events never reach it
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			second_gen_output <= 1'b0;
		end else if (run) begin
			second_gen_output <= apply_act(apply_act(apply_act(apply_act(second_gen_output,
				pick_second[1:0]), pick_second[3:2]),
				pick_second[9:8]), pick_second[11:10]);
		end
	end

	// Dead-band stage; its outputs are flip-flops
	pgd_deadband #(
		.DB_W(DB_W)
	) u_db (
		.clk(clk),
		.rst_b(rst_b),
		.enable(db_enable),
		.rise_delay(db_rise),
		.fall_delay(db_fall),
		.first_gen_output(first_gen_output),
		.second_gen_output(second_gen_output),
		.out_a(pwm_out_a),
		.out_b(pwm_out_b)
	);
endmodule // pgd_generator

// ### verilog/pgd_consts.vh
// Constants for the PWM generator unit with dead-band stage
`ifndef PGD_CONSTS_VH
`define PGD_CONSTS_VH
`define PGD_CNT_W 16
`define PGD_DB_W 12
`define PGD_ACT_W 2
`define PGD_ACT_KEEP 2'h0
`define PGD_ACT_TOGGLE 2'h1
`define PGD_ACT_LOW 2'h2
`define PGD_ACT_HIGH 2'h3
`define PGD_EV_ZERO 0
`define PGD_EV_LOAD 1
`define PGD_EV_AUP 2
`define PGD_EV_ADN 3
`define PGD_EV_BUP 4
`define PGD_EV_BDN 5
`define PGD_NEV 6
`define PGD_ACTS_W 12
`define PGD_ZERO16 16'h0000
`define PGD_ONE16 16'h0001
`endif

// ### verilog/pgd_deadband.v
// Dead-band stage: bypass or complementary pair with edge delays
`timescale 1ns/100ps
module pgd_deadband #(
	parameter DB_W = 12
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Control
	input wire enable,
	input wire [DB_W-1:0] rise_delay,
	input wire [DB_W-1:0] fall_delay,
	// Generator outputs
	input wire first_gen_output,
	input wire second_gen_output,
	// Stage outputs
	output reg out_a,
	output reg out_b
);
	reg [DB_W-1:0] cnt;
	reg src_q;
	wire [DB_W-1:0] dly;
	assign dly = src_q ? rise_delay : fall_delay;
	// A new input edge restarts the count, so short pulses are swallowed
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= {DB_W{1'b0}};
			src_q <= 1'b0;
			out_a <= 1'b0;
			out_b <= 1'b0;
		end else if (!enable) begin
			out_a <= first_gen_output;
			out_b <= second_gen_output;
			src_q <= first_gen_output;
			cnt <= {DB_W{1'b0}};
		end else if (first_gen_output != src_q) begin
			src_q <= first_gen_output;
			cnt <= {DB_W{1'b0}};
			out_a <= 1'b0;
			out_b <= 1'b0;
			if (first_gen_output && rise_delay == {DB_W{1'b0}})
				out_a <= 1'b1;
			if (!first_gen_output && fall_delay == {DB_W{1'b0}})
				out_b <= 1'b1;
		end else if (cnt < dly) begin
			cnt <= cnt + {{(DB_W-1){1'b0}}, 1'b1};
			// Neither side on until the delay runs out, also right after enabling
			out_a <= 1'b0;
			out_b <= 1'b0;
			if (cnt + {{(DB_W-1){1'b0}}, 1'b1} == dly) begin
				out_a <= src_q;
				out_b <= ~src_q;
			end
		end else begin
			out_a <= src_q;
			out_b <= ~src_q;
		end
	end
endmodule // pgd_deadband

// ### test/pgd_generator_checker.sv
// Port assertions for the PWM generator unit
`timescale 1ns/100ps
`include "pgd_consts.vh"
module pgd_checker #(
	parameter CNT_W = 16,
	parameter DB_W = 12
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Control
	input wire run,
	input wire updown_mode,
	input wire db_enable,
	input wire [`PGD_NEV-1:0] irq_select,
	// Outputs
	input wire pwm_out_a,
	input wire pwm_out_b,
	input wire irq,
	input wire direction,
	input wire [CNT_W-1:0] count,
	input wire [`PGD_NEV-1:0] events
);
	wire ev_zero = events[`PGD_EV_ZERO];
	wire ev_load = events[`PGD_EV_LOAD];
	wire ev_up = events[`PGD_EV_AUP] | events[`PGD_EV_BUP];
	wire ev_match = |events[`PGD_EV_BDN:`PGD_EV_AUP];
	wire dn_run = run && !updown_mode;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_zero_event_count: assert property (ev_zero |-> $past(count) == `PGD_ZERO16)
		else $error("zero pulse without zero count");
	a_load_after_zero: assert property (ev_zero && dn_run && !$past(updown_mode) |=> ev_load)
		else $error("no load pulse after zero");
	a_down_dir_low: assert property (dn_run |=> !direction)
		else $error("direction high in down mode");
	a_down_step: assert property (dn_run && count != `PGD_ZERO16 |=> count == $past(count) - `PGD_ONE16)
		else $error("down count step wrong");
	a_irq_selected: assert property (irq == |(events & $past(irq_select)))
		else $error("irq does not follow selected events");
	a_match_dropped: assert property (ev_match |-> !ev_zero && !ev_load)
		else $error("match kept beside zero or load");
	a_down_no_up: assert property (ev_up |-> $past(updown_mode))
		else $error("up match in down mode");
	a_db_no_overlap: assert property (db_enable |=> !(pwm_out_a && pwm_out_b))
		else $error("both stage outputs high");
	c_zero: cover property (ev_zero);
	c_adn: cover property (events[`PGD_EV_ADN]);
	c_up: cover property (ev_up);
	c_irq: cover property (irq);
endmodule // pgd_checker
bind pgd_generator pgd_checker #(.CNT_W(CNT_W), .DB_W(DB_W)) i_chk (.clk(clk), .rst_b(rst_b),
	.run(run), .updown_mode(updown_mode), .db_enable(db_enable), .irq_select(irq_select),
	.pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b), .irq(irq), .direction(direction),
	.count(count), .events(events));

// ### test/pgd_bridge_model.sv
// Half-bridge gate driver model counting shoot-through cycles
`timescale 1ns/100ps
module pgd_bridge_model (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Gate drives
	input wire high_gate,
	input wire low_gate,
	// Status
	output reg [15:0] shoot_cnt
);
	// Both switches on at once would short the supply
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shoot_cnt <= 16'h0000;
		end else if (high_gate && low_gate) begin
			shoot_cnt <= shoot_cnt + 16'h0001;
		end
	end
endmodule // pgd_bridge_model

// ### test/pgd_generator_tb.sv
// Self-checking bench for the PWM generator unit
`timescale 1ns/100ps
`include "pgd_consts.vh"
module pgd_generator_tb;
	reg clk = 1'b0;
	reg rst_b = 1'b0;
	reg run, updown_mode, load_sync_mode, cmpa_sync_mode, cmpb_sync_mode, global_update;
	reg db_enable, load_write, cmpa_write, cmpb_write;
	reg [15:0] load_value, cmpa_value, cmpb_value, len, ca, cb, shoot0;
	reg [11:0] db_rise, db_fall, acts_first, acts_second;
	reg [5:0] irq_select;
	wire pwm_out_a, pwm_out_b, irq, direction;
	wire [15:0] count, shoot_cnt;
	wire [5:0] events;
	integer error_cnt = 0, cmp_count = 0, seed = 90, i, ha, hb, per;
	always #20 clk = ~clk;
	pgd_generator i_dut (.clk(clk), .rst_b(rst_b), .run(run), .updown_mode(updown_mode),
		.load_sync_mode(load_sync_mode), .cmpa_sync_mode(cmpa_sync_mode),
		.cmpb_sync_mode(cmpb_sync_mode), .global_update(global_update), .db_enable(db_enable),
		.load_value(load_value), .load_write(load_write), .cmpa_value(cmpa_value),
		.cmpa_write(cmpa_write), .cmpb_value(cmpb_value), .cmpb_write(cmpb_write),
		.db_rise(db_rise), .db_fall(db_fall), .acts_first(acts_first),
		.acts_second(acts_second), .irq_select(irq_select), .pwm_out_a(pwm_out_a),
		.pwm_out_b(pwm_out_b), .irq(irq), .direction(direction), .count(count), .events(events));
	pgd_bridge_model i_bridge (.clk(clk), .rst_b(rst_b), .high_gate(pwm_out_a),
		.low_gate(pwm_out_b), .shoot_cnt(shoot_cnt));
	task check(input [31:0] seen, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task end_sim;
	begin
		$display("%0d compares, %0d mismatches", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	// Down mode high time: zero sets first and match ends it, second the reverse, unless dropped or out of range
	function [31:0] dn_high(input [15:0] l, input [15:0] c, input first);
	begin
		if (c == 16'h0000 || c >= l)
			dn_high = first ? l + 1 : 0;
		else
			dn_high = first ? l - c + 1 : c;
	end
	endfunction
	task wait_zero;
		integer n;
	begin
		n = 0;
		@(negedge clk);
		while (events[`PGD_EV_ZERO] !== 1'b1 && n < 200) begin
			@(negedge clk);
			n = n + 1;
		end
	end
	endtask
	// Second zero so immediate-mode pending values are surely in use; then one whole period
	task measure;
	begin
		wait_zero;
		wait_zero;
		per = 0;
		ha = 0;
		hb = 0;
		do begin
			@(negedge clk);
			per = per + 1;
			ha = ha + pwm_out_a;
			hb = hb + pwm_out_b;
		end while (events[`PGD_EV_ZERO] !== 1'b1 && per < 200);
	end
	endtask
	task cfg(input m, input [11:0] f, input [11:0] s);
	begin
		@(negedge clk);
		{updown_mode, load_value, cmpa_value, cmpb_value} = {m, len, ca, cb};
		{acts_first, acts_second} = {f, s};
		{load_write, cmpa_write, cmpb_write} = 3'h7;
		irq_select = $random(seed);
		@(negedge clk);
		{load_write, cmpa_write, cmpb_write} = 3'h0;
	end
	endtask
	initial begin
		{run, updown_mode, load_sync_mode, cmpa_sync_mode, cmpb_sync_mode, global_update} = 6'h00;
		{db_enable, load_write, cmpa_write, cmpb_write, irq_select} = 10'h000;
		{load_value, cmpa_value, cmpb_value, len, ca, cb} = 96'h0;
		{db_rise, db_fall, acts_first, acts_second} = 48'h0;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		check({pwm_out_a, pwm_out_b, irq, direction, count, events}, 32'h0);
		run = 1'b1;
		// First pass hits a match on load and a match above load
		for (i = 0; i < 4; i = i + 1) begin
			len = {$random(seed)} % 20 + 4;
			ca = (i == 0) ? len : {$random(seed)} % (len + 3);
			cb = (i == 0) ? len + 1 : {$random(seed)} % (len + 3);
			cfg(1'b0, 12'h083, 12'h402);
			measure;
			check(per, len + 1);
			check(ha, dn_high(len, ca, 1'b1));
			check(hb, dn_high(len, cb, 1'b0));
		end
		$display("down mode test done");
		for (i = 0; i < 3; i = i + 1) begin
			len = {$random(seed)} % 16 + 4;
			ca = {$random(seed)} % (len - 1) + 1;
			cb = {$random(seed)} % (len - 1) + 1;
			cfg(1'b1, 12'h0B0, 12'hB00);
			measure;
			check(per, 2 * len);
			check(ha, 2 * (len - ca));
			check(hb, 2 * (len - cb));
		end
		$display("up/down mode test done");
		{len, ca, cb} = {16'h0014, 16'h000A, 16'h0005};
		cfg(1'b0, 12'h083, 12'h402);
		{db_enable, db_rise, db_fall} = {1'b1, 12'h003, 12'h004};
		repeat (4) @(negedge clk);
		shoot0 = shoot_cnt;
		measure;
		check(ha, 8);
		check(hb, 6);
		check(shoot_cnt, shoot0);
		{db_rise, db_fall} = 24'h0;
		measure;
		check(ha, 11);
		check(hb, 10);
		db_enable = 1'b0;
		measure;
		check(hb, 5);
		$display("dead-band test done");
		cmpa_sync_mode = 1'b1;
		ca = 16'h000F;
		cfg(1'b0, 12'h083, 12'h402);
		measure;
		check(ha, 11);
		global_update = 1'b1;
		@(negedge clk);
		global_update = 1'b0;
		measure;
		check(ha, 6);
		{load_sync_mode, cmpb_sync_mode} = 2'h3;
		{len, cb} = {16'h0018, 16'h0008};
		cfg(1'b0, 12'h083, 12'h402);
		measure;
		check(per, 21);
		check(hb, 5);
		global_update = 1'b1;
		@(negedge clk);
		global_update = 1'b0;
		measure;
		check(per, 25);
		check(ha, 10);
		check(hb, 8);
		$display("update mode test done");
		end_sim;
	end
	// Whole run is about a thousand cycles; far beyond that means a hang
	initial begin
		#(40 * 20000);
		error_cnt = error_cnt + 1;
		end_sim;
	end
endmodule // pgd_generator_tb
